// file: design/pll_regs.vh
// Register map, field positions, reset values and timing constants of the PLL control block
`ifndef PLL_REGS_VH
`define PLL_REGS_VH

// ==========================================================
// Register byte offsets
`define CTRL_OFS 6'h00
`define DIV_OFS 6'h04
`define STAT_OFS 6'h08
`define SCAN_OFS 6'h0C
`define POST_BASE 6'h10
`define POST_END 6'h38
`define POST_BASE_IDX 4'h4

// ==========================================================
// Control register fields
`define CTRL_AUTO 0
`define CTRL_EXTFB 1
`define CTRL_DIFF 2
`define CTRL_INV 3
`define CTRL_RST 32'h00000004

// ==========================================================
// Divider register fields, values stored as factor minus one
`define DIV_N_LSB 0
`define DIV_M_LSB 16
`define DIV_RST 32'h00000000

// ==========================================================
// Post-scale register fields
`define POST_DUTY50 10
`define POST_HI_LSB 12
`define POST_RST 21'h000401

// ==========================================================
// Status register fields
`define ST_LOCK 0
`define ST_LOSS 1
`define ST_BAD0 2
`define ST_BAD1 3
`define ST_ACT 4
`define ST_UP 5
`define ST_DN 6

// ==========================================================
// Synchroniser lanes
`define S_FBIN 2
`define S_ENA 3
`define S_SCLK 4
`define S_SDATA 5
`define S_SWITCH 6

// ==========================================================
// Counter layout and timing
`define G0_IDX 2
`define EXT_IDX 6
`define CLK_PERIOD_NS 25
`define LOSS_TIME_NS 1000
`define LOSS_CYC 16'h0028 // LOSS_TIME_NS over CLK_PERIOD_NS, rounded up
`define LOCK_WIN 16'h0004
`define LOCK_CNT 8'h10
`define NCO_RST 16'h1000
`define NCO_STEP 16'h0010
`define NCO_MIN 16'h0040
`define NCO_MAX 16'hFF00

`endif

// file: design/enhanced_pll_control.v
// Digital control, switchover, scan chain and counter synthesis of an enhanced PLL
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "pll_regs.vh"

// ==========================================================
// Summary of operation
// - Loop runs only while the synchronised enable pin is high.
// - Manual reference switchover starts only on a rising edge of the swap request.
// - Loop reset holds the loop and restarts every divider counter aligned.
// - Each of six internal clock outputs toggles only while its gate is high.
// - Each of four external outputs has its own gate, only on multi-pin PLLs.
// - Detector up and down reach the loop only while the detector gate is high.
// - Scan chain shifts in one serial data bit per scan clock rising edge.
// - Chain clear input high clears every scan chain register.
// - Serial scan output shows the last chain stage.
// - Source loss flag rises when the active reference is found dead.
// - Two dead-source flags, bit 1 for reference 1, bit 0 for reference 0.
// - Lock indication is high once the loop has achieved lock.
// - Active clock output is 1 for reference 0, 0 for reference 1.
// - Reference is divided by n, feedback by m, so VCO tends to fin*m/n.
// - Every internal clock and every external pair has its own post-scale counter dividing the VCO.
// - One n and one m counter, each taking factors 1 to 512.
// - Post-scale counters: two regional, four global, four external.
// - Post-scale range 1 to 1024 at 50% duty, else 1 to 512.
// - On single-output PLLs the g0 counter drives that pin.
// - External feedback pin replaces internal feedback, multi-pin PLLs only.
// - Primary and secondary references come from pins, chosen one feeds n.
// - External counters drive four differential pairs or eight single pins.

module enhanced_pll_control #(
    parameter HAS_EXT_OUT = 1,
    parameter HAS_SINGLE_OUT = 0,
    parameter SCAN_LEN = 64,
    parameter [15:0] LOSS_CYCLES = `LOSS_CYC,
    parameter [7:0] LOCK_COUNT = `LOCK_CNT
) (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire [1:0] INCLK,
    input wire FBIN,
    input wire PLLENA,
    input wire CLKSWITCH,
    input wire ARESET,
    input wire [5:0] CLKENA,
    input wire [3:0] EXTCLKENA,
    input wire PFDENA,
    input wire SCANCLK,
    input wire SCANDATA,
    input wire SCANACLR,
    input wire [5:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    output reg [5:0] CLK,
    output reg [3:0] PLL_OUTP,
    output reg [3:0] PLL_OUTN,
    output reg SINGLE_PIN_CLOCK_OUT,
    output reg CLKLOSS,
    output reg [1:0] CLKBAD,
    output reg LOCKED,
    output reg ACTIVECLOCK,
    output wire SCANDATAOUT
);

    localparam NSYNC = 7;
    localparam NUM_POST = 10;
    localparam NUM_INT = 6;
    localparam NUM_EXT = 4;

    // ==========================================================
    // Helper functions

    // Counter step that wraps to zero at the programmed limit
    function [9:0] wrap;
        input [9:0] c;
        input [9:0] lim;
        begin
            wrap = (c >= lim) ? 10'h000 : c + 10'h001;
        end
    endfunction

    // Post-scale limit; a non-50% duty setting caps the factor at 512
    function [9:0] post_lim;
        input [20:0] cfg;
        begin
            post_lim = cfg[`POST_DUTY50] ? cfg[9:0] : {1'b0, cfg[8:0]};
        end
    endfunction

    // Output level for a counter value; odd 50% factors round high time down
    function post_level;
        input [9:0] c;
        input [20:0] cfg;
        reg [10:0] half;
        begin
            half = ({1'b0, cfg[9:0]} + 11'h001) >> 1;
            if (cfg[`POST_DUTY50])
                post_level = ({1'b0, c} < half);
            else
                post_level = (c[8:0] <= cfg[`POST_HI_LSB+8:`POST_HI_LSB]);
        end
    endfunction

    function post_hit;
        input [5:0] a;
        begin
            post_hit = (a >= `POST_BASE) && (a < `POST_END) && (a[1:0] == 2'b00);
        end
    endfunction

    function [3:0] post_idx;
        input [5:0] a;
        begin
            post_idx = a[5:2] - `POST_BASE_IDX;
        end
    endfunction

    // ==========================================================
    // Pin synchronisers: first stage is read only by the second
    reg [NSYNC-1:0] meta_r;
    reg [NSYNC-1:0] sync_r;
    reg [NSYNC-1:0] prev_r;
    wire [NSYNC-1:0] sin = {CLKSWITCH, SCANDATA, SCANCLK, PLLENA, FBIN, INCLK};
    wire [NSYNC-1:0] rise = sync_r & ~prev_r;
    wire [NSYNC-1:0] chg = sync_r ^ prev_r;

    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            meta_r <= {NSYNC{1'b0}};
            sync_r <= {NSYNC{1'b0}};
            prev_r <= {NSYNC{1'b0}};
        end else begin
            meta_r <= sin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // ==========================================================
    // Software registers
    reg [31:0] ctrl_r;
    reg [31:0] div_r;
    reg [20:0] post_cfg_r [0:NUM_POST-1];
    reg [SCAN_LEN-1:0] chain_r;
    // One loop index per process, so no variable has two drivers
    integer i;
    integer li;
    integer pi;
    integer oi;

    wire [9:0] n_val = {1'b0, div_r[`DIV_N_LSB+8:`DIV_N_LSB]};
    wire [9:0] m_val = {1'b0, div_r[`DIV_M_LSB+8:`DIV_M_LSB]};
    wire ext_fb = ctrl_r[`CTRL_EXTFB] & (HAS_EXT_OUT != 0);

    // Writes; a write to an unmapped offset is dropped
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_r <= `CTRL_RST;
            div_r <= `DIV_RST;
            for (i = 0; i < NUM_POST; i = i + 1)
                post_cfg_r[i] <= `POST_RST;
        end else if (WR) begin
            if (ADDR == `CTRL_OFS)
                ctrl_r <= {28'h0000000, WDATA[3:0]};
            if (ADDR == `DIV_OFS)
                div_r <= {7'h00, WDATA[`DIV_M_LSB+8:`DIV_M_LSB], 7'h00, WDATA[`DIV_N_LSB+8:`DIV_N_LSB]};
            if (post_hit(ADDR))
                post_cfg_r[post_idx(ADDR)] <= WDATA[20:0];
        end
    end

    // ==========================================================
    // Clock loss detection and switchover
    reg [15:0] loss_cnt_r [0:1];
    reg [1:0] bad_r;
    reg sel_r; // 0 selects reference 0
    wire loop_rst = SYS_RST | ARESET | ~sync_r[`S_ENA];
    wire swap_req = rise[`S_SWITCH];
    wire auto_sw = ctrl_r[`CTRL_AUTO] & bad_r[sel_r] & ~bad_r[~sel_r];

    // A reference with no level change for LOSS_CYCLES is declared dead
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            loss_cnt_r[0] <= 16'h0000;
            loss_cnt_r[1] <= 16'h0000;
            bad_r <= 2'b00;
        end else begin
            for (li = 0; li < 2; li = li + 1) begin
                if (chg[li]) begin
                    loss_cnt_r[li] <= 16'h0000;
                    bad_r[li] <= 1'b0;
                end else if (loss_cnt_r[li] < LOSS_CYCLES) begin
                    loss_cnt_r[li] <= loss_cnt_r[li] + 16'h0001;
                end else begin
                    bad_r[li] <= 1'b1;
                end
            end
        end
    end

    // Manual swap on the edge, automatic swap only toward a live source
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sel_r <= 1'b0;
            CLKLOSS <= 1'b0;
            CLKBAD <= 2'b00;
            ACTIVECLOCK <= 1'b1;
        end else begin
            if (swap_req | auto_sw)
                sel_r <= ~sel_r;
            CLKLOSS <= bad_r[sel_r];
            CLKBAD <= bad_r;
            ACTIVECLOCK <= ~sel_r;
        end
    end

    // ==========================================================
    // Pre-scale and feedback counters
    reg [9:0] n_cnt_r;
    reg [9:0] m_cnt_r;
    reg ref_tick_r;
    reg fb_int_r;
    reg vco_tick_r;
    wire ref_rise = rise[sel_r];
    wire fb_tick = ext_fb ? rise[`S_FBIN] : fb_int_r;

    always @(posedge REF_CLK) begin
        if (loop_rst) begin
            n_cnt_r <= 10'h000;
            m_cnt_r <= 10'h000;
            ref_tick_r <= 1'b0;
            fb_int_r <= 1'b0;
        end else begin
            ref_tick_r <= ref_rise & (n_cnt_r >= n_val);
            if (ref_rise)
                n_cnt_r <= wrap(n_cnt_r, n_val);
            fb_int_r <= vco_tick_r & (m_cnt_r >= m_val);
            if (vco_tick_r)
                m_cnt_r <= wrap(m_cnt_r, m_val);
        end
    end

    // ==========================================================
    // Phase frequency detector, lock detect and VCO model
    reg up_r;
    reg dn_r;
    reg [15:0] err_r;
    reg [7:0] lock_cnt_r;
    reg [15:0] inc_r;
    reg [15:0] acc_r;
    wire up_nxt = up_r | ref_tick_r;
    wire dn_nxt = dn_r | fb_tick;
    wire pfd_up = up_r & PFDENA;
    wire pfd_dn = dn_r & PFDENA;
    wire [16:0] acc_nxt = {1'b0, acc_r} + {1'b0, inc_r};

    // Both flags set means the edges paired; the gap between them is the error
    always @(posedge REF_CLK) begin
        if (loop_rst) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
            err_r <= 16'h0000;
            lock_cnt_r <= 8'h00;
        end else if (up_nxt & dn_nxt) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
            err_r <= 16'h0000;
            if (err_r > `LOCK_WIN)
                lock_cnt_r <= 8'h00;
            else if (lock_cnt_r < LOCK_COUNT)
                lock_cnt_r <= lock_cnt_r + 8'h01;
        end else begin
            up_r <= up_nxt;
            dn_r <= dn_nxt;
            if ((up_r | dn_r) && err_r != 16'hFFFF)
                err_r <= err_r + 16'h0001;
        end
    end

    // Lock is cleared at once by reset or disable and returns only via the counter
    always @(posedge REF_CLK) begin
        if (loop_rst)
            LOCKED <= 1'b0;
        else
            LOCKED <= (lock_cnt_r == LOCK_COUNT);
    end

    // Integrating control: each cycle of gated error nudges the VCO rate
    always @(posedge REF_CLK) begin
        if (loop_rst) begin
            inc_r <= `NCO_RST;
            acc_r <= 16'h0000;
            vco_tick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt[15:0];
            vco_tick_r <= acc_nxt[16];
            if (pfd_up && !pfd_dn && inc_r < `NCO_MAX)
                inc_r <= inc_r + `NCO_STEP;
            else if (pfd_dn && !pfd_up && inc_r > `NCO_MIN)
                inc_r <= inc_r - `NCO_STEP;
        end
    end

    // ==========================================================
    // Post-scale counters: 0-1 regional, 2-5 global, 6-9 external
    reg [9:0] post_cnt_r [0:NUM_POST-1];
    reg [NUM_POST-1:0] lvl_r;

    // All counters restart from zero together so outputs come back aligned
    always @(posedge REF_CLK) begin
        if (loop_rst) begin
            lvl_r <= {NUM_POST{1'b0}};
            for (pi = 0; pi < NUM_POST; pi = pi + 1)
                post_cnt_r[pi] <= 10'h000;
        end else if (vco_tick_r) begin
            for (pi = 0; pi < NUM_POST; pi = pi + 1) begin
                post_cnt_r[pi] <= wrap(post_cnt_r[pi], post_lim(post_cfg_r[pi]));
                lvl_r[pi] <= post_level(wrap(post_cnt_r[pi], post_lim(post_cfg_r[pi])), post_cfg_r[pi]);
            end
        end
    end

    // ==========================================================
    // Gated outputs; a gated-off output parks low
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            CLK <= 6'h00;
            PLL_OUTP <= 4'h0;
            PLL_OUTN <= 4'h0;
            SINGLE_PIN_CLOCK_OUT <= 1'b0;
        end else begin
            CLK <= lvl_r[NUM_INT-1:0] & CLKENA;
            for (oi = 0; oi < NUM_EXT; oi = oi + 1) begin
                if (EXTCLKENA[oi] && HAS_EXT_OUT != 0) begin
                    PLL_OUTP[oi] <= lvl_r[`EXT_IDX+oi];
                    if (ctrl_r[`CTRL_DIFF] | ctrl_r[`CTRL_INV])
                        PLL_OUTN[oi] <= ~lvl_r[`EXT_IDX+oi];
                    else
                        PLL_OUTN[oi] <= lvl_r[`EXT_IDX+oi];
                end else begin
                    PLL_OUTP[oi] <= 1'b0;
                    PLL_OUTN[oi] <= 1'b0;
                end
            end
            SINGLE_PIN_CLOCK_OUT <= (HAS_SINGLE_OUT != 0) & lvl_r[`G0_IDX];
        end
    end

    // ==========================================================
    // Reconfiguration scan chain, clocked by the synchronised scan clock edge
    always @(posedge REF_CLK) begin
        if (SYS_RST | SCANACLR)
            chain_r <= {SCAN_LEN{1'b0}};
        else if (rise[`S_SCLK])
            chain_r <= {chain_r[SCAN_LEN-2:0], sync_r[`S_SDATA]};
    end

    assign SCANDATAOUT = chain_r[SCAN_LEN-1];

    // ==========================================================
    // Read port: data stands one cycle after the strobe and reads zero otherwise
    always @(posedge REF_CLK) begin
        if (SYS_RST || !RD) begin
            RDATA <= 32'h00000000;
        end else if (ADDR == `CTRL_OFS) begin
            RDATA <= ctrl_r;
        end else if (ADDR == `DIV_OFS) begin
            RDATA <= div_r;
        end else if (ADDR == `STAT_OFS) begin
            RDATA <= 32'h00000000;
            RDATA[`ST_LOCK] <= LOCKED;
            RDATA[`ST_LOSS] <= CLKLOSS;
            RDATA[`ST_BAD0] <= CLKBAD[0];
            RDATA[`ST_BAD1] <= CLKBAD[1];
            RDATA[`ST_ACT] <= ACTIVECLOCK;
            RDATA[`ST_UP] <= pfd_up;
            RDATA[`ST_DN] <= pfd_dn;
        end else if (ADDR == `SCAN_OFS) begin
            RDATA <= chain_r[31:0];
        end else if (post_hit(ADDR)) begin
            RDATA <= {11'h000, post_cfg_r[post_idx(ADDR)]};
        end else begin
            RDATA <= 32'h00000000;
        end
    end

endmodule

// file: bench/enhanced_pll_control_assertions.sv
// Concurrent checks on the ports of the PLL control block
`timescale 1ns/1ps
module pll_ctrl_checker #(
    parameter [15:0] LOSS_CYCLES = 16'h0028
) (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire [1:0] INCLK,
    input wire PLLENA,
    input wire CLKSWITCH,
    input wire ARESET,
    input wire [5:0] CLKENA,
    input wire [3:0] EXTCLKENA,
    input wire SCANACLR,
    input wire RD,
    input wire [31:0] RDATA,
    input wire [5:0] CLK,
    input wire [3:0] PLL_OUTP,
    input wire [3:0] PLL_OUTN,
    input wire CLKLOSS,
    input wire [1:0] CLKBAD,
    input wire LOCKED,
    input wire ACTIVECLOCK,
    input wire SCANDATAOUT
);
    reg [15:0] still_r;
    reg prev_r;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    // ==========================================
    // Cycles since reference 0 last changed, saturating so it never wraps back to calm
    always @(posedge REF_CLK) begin
        prev_r <= INCLK[0];
        if (SYS_RST || INCLK[0] != prev_r)
            still_r <= 16'h0000;
        else if (still_r != 16'hFFFF)
            still_r <= still_r + 16'h0001;
    end

    // ==========================================
    // Swap request and settled source flags
    sequence swap_rise;
        !CLKSWITCH ##1 CLKSWITCH;
    endsequence
    sequence calm_sources;
        ($stable(CLKBAD) && $stable(ACTIVECLOCK)) [*2];
    endsequence

    // ==========================================
    // Port relations
    gate_int_a: assert property ((CLK & ~$past(CLKENA)) == 6'h00)
        else $error("internal clock moved with its gate low");
    gate_ext_a: assert property (((PLL_OUTP | PLL_OUTN) & ~$past(EXTCLKENA)) == 4'h0)
        else $error("external clock moved with its gate low");
    lock_reset_a: assert property (ARESET |=> !LOCKED)
        else $error("lock stayed high through loop reset");
    lock_ena_a: assert property (!PLLENA [*4] |-> !LOCKED)
        else $error("lock high while loop disabled");
    swap_edge_a: assert property (swap_rise |-> ##[2:6] $changed(ACTIVECLOCK))
        else $error("swap request edge did not move the source");
    swap_once_a: assert property (CLKSWITCH [*8] |=> $stable(ACTIVECLOCK))
        else $error("held swap request caused a second swap");
    loss_map_a: assert property (calm_sources |-> CLKLOSS == (ACTIVECLOCK ? CLKBAD[0] : CLKBAD[1]))
        else $error("loss flag does not follow the active source");
    read_idle_a: assert property (!$past(RD) |-> RDATA == 32'h00000000)
        else $error("read data outside the read answer cycle");
    scan_clear_a: assert property (SCANACLR |=> !SCANDATAOUT)
        else $error("scan output not cleared");
    dead_ref_a: assert property (still_r > LOSS_CYCLES + 16'h0006 |-> CLKBAD[0])
        else $error("stopped reference 0 not flagged");
endmodule

// file: bench/ref_scan_source.sv
// Reference pins and serial scan source on the user side of the PLL
`timescale 1ns/1ps
module ref_scan_source (
    input wire clk,
    input wire [1:0] run,
    output logic [1:0] inclk,
    output logic sclk,
    output logic sdata
);
    logic [3:0] ph_r = 4'h0;
    initial begin
        inclk = 2'b00;
        sclk = 1'b0;
        sdata = 1'b0;
    end

    // ==========================================
    // Two references, period 16 cycles, offset phase; a stopped one freezes like a dead oscillator
    always @(posedge clk) begin
        ph_r <= ph_r + 4'h1;
        if (ph_r[2:0] == 3'h7 && run[0])
            inclk[0] <= ~inclk[0];
        if (ph_r[2:0] == 3'h3 && run[1])
            inclk[1] <= ~inclk[1];
    end

    // ==========================================
    // One scan bit: data set while the shift clock is low, each phase two cycles for the synchroniser
    task shift_bit(input logic b);
        @(posedge clk);
        sdata <= b;
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
endmodule

// file: bench/tb_enhanced_pll_control.sv
// Self-checking bench for the PLL control block
`timescale 1ns/1ps
module tb_enhanced_pll_control;
    logic REF_CLK = 1'b0, SYS_RST = 1'b1, FBIN = 1'b0, PLLENA = 1'b1, CLKSWITCH = 1'b0;
    logic ARESET = 1'b0, PFDENA = 1'b1, SCANACLR = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [5:0] CLKENA = 6'h3F, ADDR = 6'h00;
    logic [3:0] EXTCLKENA = 4'hF;
    logic [31:0] WDATA = 32'h00000000;
    logic [1:0] run = 2'b11;
    wire [1:0] INCLK;
    wire SCANCLK, SCANDATA, SINGLE_PIN_CLOCK_OUT, CLKLOSS, LOCKED, ACTIVECLOCK, SCANDATAOUT;
    wire [31:0] RDATA;
    wire [5:0] CLK;
    wire [3:0] PLL_OUTP, PLL_OUTN;
    wire [1:0] CLKBAD;
    int n_mismatch = 0, checked = 0, i;
    logic [15:0] seed = 16'h6646;
    logic [9:0] tg;
    logic [63:0] sd;
    logic [5:0] a;

    // Dead-source span shortened so the stop tests stay brief
    enhanced_pll_control #(.LOSS_CYCLES(16'h0014), .LOCK_COUNT(8'h02)) dut (
        .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .INCLK(INCLK), .FBIN(FBIN), .PLLENA(PLLENA),
        .CLKSWITCH(CLKSWITCH), .ARESET(ARESET), .CLKENA(CLKENA), .EXTCLKENA(EXTCLKENA),
        .PFDENA(PFDENA), .SCANCLK(SCANCLK), .SCANDATA(SCANDATA), .SCANACLR(SCANACLR),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CLK(CLK),
        .PLL_OUTP(PLL_OUTP), .PLL_OUTN(PLL_OUTN), .SINGLE_PIN_CLOCK_OUT(SINGLE_PIN_CLOCK_OUT),
        .CLKLOSS(CLKLOSS), .CLKBAD(CLKBAD), .LOCKED(LOCKED), .ACTIVECLOCK(ACTIVECLOCK),
        .SCANDATAOUT(SCANDATAOUT));
    ref_scan_source src (.clk(REF_CLK), .run(run), .inclk(INCLK), .sclk(SCANCLK), .sdata(SCANDATA));

    always #12.5 REF_CLK = ~REF_CLK;

    // ==========================================
    // Bench helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected negative legs: inverted in differential mode, parked low when gated
    function automatic logic [3:0] n_leg(input logic [3:0] p, input logic [3:0] e, input logic inv);
        return (inv ? ~p : p) & e;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [5:0] ad, input logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= ad;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    // Read data is valid only in the cycle after the strobe, so it is taken at that negedge
    task rdchk(input logic [5:0] ad, input logic [31:0] m, input logic [31:0] e);
        @(posedge REF_CLK);
        ADDR <= ad;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        @(negedge REF_CLK);
        check(RDATA & m, e);
    endtask
    task wait_lock;
        for (int k = 0; k < 8000 && LOCKED !== 1'b1; k++)
            @(negedge REF_CLK);
        check({31'h0, LOCKED}, 32'h1);
    endtask
    // Bits of CLK and PLL_OUTP that moved over 80 cycles, after gate changes settle
    task toggles(output logic [9:0] t);
        logic [9:0] p;
        repeat (3) @(negedge REF_CLK);
        t = 10'h000;
        p = {PLL_OUTP, CLK};
        repeat (80) begin
            @(negedge REF_CLK);
            t = t | (p ^ {PLL_OUTP, CLK});
            p = {PLL_OUTP, CLK};
        end
    endtask
    task pulse_swap(input int len);
        @(posedge REF_CLK);
        CLKSWITCH <= 1'b1;
        repeat (len) @(posedge REF_CLK);
        CLKSWITCH <= 1'b0;
        repeat (6) @(negedge REF_CLK);
    endtask
    task wrap_up;
        $display("Mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================
    // Watchdog, sized above three lock waits plus the rest
    initial begin
        #(25 * 60000);
        n_mismatch = n_mismatch + 1;
        wrap_up;
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        rdchk(6'h00, 32'hFFFFFFFF, 32'h00000004);
        rdchk(6'h04, 32'hFFFFFFFF, 32'h00000000);
        rdchk(6'h38, 32'hFFFFFFFF, 32'h00000000);
        wr(6'h04, 32'h01FF01FF);
        rdchk(6'h04, 32'hFFFFFFFF, 32'h01FF01FF);
        seed = lfsr(seed);
        wr(6'h04, {seed, seed});
        rdchk(6'h04, 32'hFFFFFFFF, {seed, seed} & 32'h01FF01FF);
        wr(6'h04, 32'h00000000);
        wr(6'h10, 32'h000007FF);
        rdchk(6'h10, 32'hFFFFFFFF, 32'h000007FF);
        wr(6'h10, 32'h00000401);
        for (i = 0; i < 10; i++) begin
            a = 6'h10 + {i[3:0], 2'b00};
            rdchk(a, 32'hFFFFFFFF, 32'h00000401);
            seed = lfsr(seed);
            wr(a, {11'h0, seed[4:0], seed});
            rdchk(a, 32'hFFFFFFFF, {11'h0, seed[4:0], seed} & 32'h001FFFFF);
            wr(a, 32'h00000401);
        end
        wait_lock;
        @(posedge REF_CLK);
        ARESET <= 1'b1;
        @(posedge REF_CLK);
        ARESET <= 1'b0;
        repeat (2) @(negedge REF_CLK);
        check({31'h0, LOCKED}, 32'h0);
        wait_lock;
        @(posedge REF_CLK);
        PLLENA <= 1'b0;
        repeat (6) @(negedge REF_CLK);
        check({31'h0, LOCKED}, 32'h0);
        @(posedge REF_CLK);
        PLLENA <= 1'b1;
        wait_lock;
        @(posedge REF_CLK);
        PFDENA <= 1'b0;
        for (i = 0; i < 8; i++)
            rdchk(6'h08, 32'h00000060, 32'h00000000);
        @(posedge REF_CLK);
        PFDENA <= 1'b1;
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(6'h00, {29'h0, seed[10], 2'b00});
            @(posedge REF_CLK);
            CLKENA <= seed[5:0];
            EXTCLKENA <= seed[9:6];
            toggles(tg);
            check({22'h0, tg}, {22'h0, seed[9:0]});
            check({28'h0, PLL_OUTN}, {28'h0, n_leg(PLL_OUTP, EXTCLKENA, seed[10])});
        end
        pulse_swap(1);
        check({31'h0, ACTIVECLOCK}, 32'h0);
        for (i = 0; i < 2; i++) begin
            @(posedge REF_CLK);
            run <= (i == 0) ? 2'b10 : 2'b01;
            repeat (40) @(negedge REF_CLK);
            check({30'h0, CLKBAD}, (i == 0) ? 32'h1 : 32'h2);
            check({31'h0, CLKLOSS}, (i == 1) ? 32'h1 : 32'h0);
            @(posedge REF_CLK);
            run <= 2'b11;
            repeat (40) @(negedge REF_CLK);
            check({30'h0, CLKBAD}, 32'h0);
        end
        pulse_swap(12);
        check({31'h0, ACTIVECLOCK}, 32'h1);
        // Automatic mode: the active reference dies, so the live one takes over
        wr(6'h00, 32'h00000005);
        @(posedge REF_CLK);
        run <= 2'b10;
        repeat (40) @(negedge REF_CLK);
        check({31'h0, ACTIVECLOCK}, 32'h0);
        @(posedge REF_CLK);
        run <= 2'b11;
        wr(6'h00, 32'h00000004);
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            sd[16 * i +: 16] = seed;
        end
        for (i = 63; i >= 0; i--)
            src.shift_bit(sd[i]);
        repeat (4) @(negedge REF_CLK);
        check({31'h0, SCANDATAOUT}, {31'h0, sd[63]});
        rdchk(6'h0C, 32'hFFFFFFFF, sd[31:0]);
        @(posedge REF_CLK);
        SCANACLR <= 1'b1;
        @(posedge REF_CLK);
        SCANACLR <= 1'b0;
        rdchk(6'h0C, 32'hFFFFFFFF, 32'h00000000);
        check({31'h0, SCANDATAOUT}, 32'h0);
        check({31'h0, SINGLE_PIN_CLOCK_OUT}, 32'h0);
        // External feedback with a silent pin: down never sets again, up waits alone
        wr(6'h00, 32'h00000006);
        repeat (40) @(posedge REF_CLK);
        rdchk(6'h08, 32'h00000060, 32'h00000020);
        wrap_up;
    end
endmodule

bind enhanced_pll_control pll_ctrl_checker #(.LOSS_CYCLES(LOSS_CYCLES)) chk (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .INCLK(INCLK), .PLLENA(PLLENA), .CLKSWITCH(CLKSWITCH),
    .ARESET(ARESET), .CLKENA(CLKENA), .EXTCLKENA(EXTCLKENA), .SCANACLR(SCANACLR), .RD(RD),
    .RDATA(RDATA), .CLK(CLK), .PLL_OUTP(PLL_OUTP), .PLL_OUTN(PLL_OUTN), .CLKLOSS(CLKLOSS),
    .CLKBAD(CLKBAD), .LOCKED(LOCKED), .ACTIVECLOCK(ACTIVECLOCK), .SCANDATAOUT(SCANDATAOUT));
